// file: abcd_alu.sv
// Purpose: Add, add-with-carry and AND with flag generation
// Assumes: Operands settle within one clock
// Notes: Purely combinational; the core registers the outputs
`timescale 1ns/10ps
`include "abcd_params.svh"

module abcd_alu
    import abcd_pkg::*;
(
    input wire abcd_pkg::abcd_op_type op_i,
    input wire logic [7:0] work_i,
    input wire logic [7:0] operand_i,
    input wire logic carry_i,
    output logic [7:0] result_o,
    output logic [4:0] flags_o,
    output logic [4:0] flag_mask_o
);
    import abcd_pkg::*;

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic cin;
    logic is_and;
    logic is_add;

    always_comb
    begin
        is_and = (op_i == OP_AND_LIT) || (op_i == OP_AND_FILE);
        is_add = (op_i == OP_ADD_LIT) || (op_i == OP_ADD_FILE) || (op_i == OP_ADDC_FILE);
        cin = (op_i == OP_ADDC_FILE) ? carry_i : 1'b0;
        sum = {1'b0, work_i} + {1'b0, operand_i} + {8'h00, cin};
        low_sum = {1'b0, work_i[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, cin};
        result_o = is_and ? (work_i & operand_i) : sum[7:0];
        flags_o = '0;
        flags_o[`ABCD_FLAG_C] = sum[8];
        flags_o[`ABCD_FLAG_NIB] = low_sum[4];
        flags_o[`ABCD_FLAG_SRANGE] = (work_i[7] == operand_i[7]) && (sum[7] != work_i[7]);
        flags_o[`ABCD_FLAG_N] = result_o[7];
        flags_o[`ABCD_FLAG_Z] = (result_o == 8'h00);
        // Adds touch all five flags, AND only sign and zero; other opcodes touch nothing
        flag_mask_o = '0;
        if (is_add)
        begin
            flag_mask_o = 5'h1f;
        end
        else if (is_and)
        begin
            flag_mask_o[`ABCD_FLAG_N] = 1'b1;
            flag_mask_o[`ABCD_FLAG_Z] = 1'b1;
        end
    end

endmodule

// file: abcd_core.sv
// Purpose: Executes add, add-with-carry, AND and branch-on-carry words
// Assumes: Classic Wishbone slave; one instruction at a time
// Notes: Writes to the instruction register start a four-phase cycle
`timescale 1ns/10ps
`include "abcd_params.svh"

module abcd_core
    import abcd_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int MEM_AW = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic busy_o
);
    import abcd_pkg::*;

    // ****************************************
    // State
    // ****************************************
    abcd_phase_type phase_reg;
    abcd_op_type op_reg;
    abcd_op_type op_next;
    logic extra_reg;
    logic taken_reg;
    logic [15:0] insn_reg;
    logic [7:0] working_register_reg;
    logic [4:0] flags_reg;
    logic [3:0] bank_select_register_reg;
    logic [PC_W-1:0] program_counter_reg;
    logic [MEM_AW-1:0] maddr_reg;
    logic [7:0] operand_reg;
    logic [7:0] result_reg;
    logic [4:0] new_flags_reg;
    logic [4:0] mask_reg;
    logic ack_reg;
    logic [31:0] dat_reg;

    logic [7:0] alu_result;
    logic [4:0] alu_flags;
    logic [4:0] alu_mask;
    logic [MEM_AW-1:0] file_addr;
    logic [MEM_AW-1:0] mem_addr;
    logic [7:0] mem_rd;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic is_file_op;
    logic idle;
    logic bus_req;
    logic bus_wr;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic [PC_W-1:0] branch_offset;

    assign idle = (phase_reg == PH_IDLE);
    assign busy_o = !idle;
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign is_file_op = (op_reg == OP_ADD_FILE) || (op_reg == OP_ADDC_FILE)
        || (op_reg == OP_AND_FILE);

    // ****************************************
    // Decode
    // ****************************************
    assign op_next = (insn_reg[15:8] == `ABCD_OPC_ADD_LIT) ? OP_ADD_LIT
        : (insn_reg[15:8] == `ABCD_OPC_AND_LIT) ? OP_AND_LIT
        : (insn_reg[15:8] == `ABCD_OPC_BRANCH) ? OP_BRANCH
        : (insn_reg[15:10] == `ABCD_OPC_ADD_FILE) ? OP_ADD_FILE
        : (insn_reg[15:10] == `ABCD_OPC_ADDC_FILE) ? OP_ADDC_FILE
        : (insn_reg[15:10] == `ABCD_OPC_AND_FILE) ? OP_AND_FILE
        : OP_NONE;

    // Access bank maps low half to the first bank, high half to the last
    assign file_addr = insn_reg[`ABCD_BIT_A]
        ? {bank_select_register_reg, insn_reg[7:0]}
        : (insn_reg[7:0] < `ABCD_ACCESS_SPLIT) ? {`ABCD_ACCESS_LOW_BANK, insn_reg[7:0]}
        : {`ABCD_ACCESS_HIGH_BANK, insn_reg[7:0]};

    assign branch_offset = {{(PC_W-9){insn_reg[7]}}, insn_reg[7:0], 1'b0};

    abcd_alu u_alu (
        .op_i(op_reg),
        .work_i(working_register_reg),
        .operand_i(operand_reg),
        .carry_i(flags_reg[`ABCD_FLAG_C]),
        .result_o(alu_result),
        .flags_o(alu_flags),
        .flag_mask_o(alu_mask)
    );

    // ****************************************
    // Bus slave
    // ****************************************
    assign bus_req = cyc_i && stb_i;
    // Register writes are ignored while an instruction runs
    assign bus_wr = bus_req && ack_reg && we_i && idle;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wr_word[i*8 +: 8] = sel_i[i] ? dat_i[i*8 +: 8] : rd_word[i*8 +: 8];
        end
    end

    always_comb
    begin
        rd_word = '0;
        unique case (adr_i)
            `ABCD_OFS_INSN: rd_word[15:0] = insn_reg;
            `ABCD_OFS_WORK: rd_word[7:0] = working_register_reg;
            `ABCD_OFS_FLAGS:
            begin
                rd_word[4:0] = flags_reg;
                rd_word[`ABCD_FLAG_BUSY] = !idle;
            end
            `ABCD_OFS_BANK: rd_word[3:0] = bank_select_register_reg;
            `ABCD_OFS_PC: rd_word[PC_W-1:0] = program_counter_reg;
            `ABCD_OFS_MADDR: rd_word[MEM_AW-1:0] = maddr_reg;
            `ABCD_OFS_MDATA: rd_word[7:0] = mem_rd;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end
        else
        begin
            ack_reg <= bus_req && !ack_reg;
            if (bus_req && !ack_reg)
                dat_reg <= rd_word;
        end
    end

    // ****************************************
    // Data memory port
    // ****************************************
    assign mem_addr = idle ? maddr_reg : file_addr;
    assign mem_we = idle ? (bus_wr && adr_i == `ABCD_OFS_MDATA)
        : (phase_reg == PH_WRITE && !extra_reg && is_file_op && insn_reg[`ABCD_BIT_D]);
    assign mem_wdata = idle ? wr_word[7:0] : result_reg;

    abcd_data_mem #(
        .ADDR_W(MEM_AW)
    ) u_mem (
        .clk_i(clk_i),
        .addr_i(mem_addr),
        .wr_en_i(mem_we),
        .wr_data_i(mem_wdata),
        .rd_data_o(mem_rd)
    );

    // ****************************************
    // Phase sequencer
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_reg <= PH_IDLE;
            extra_reg <= 1'b0;
        end
        else
        begin
            unique case (phase_reg)
                PH_IDLE:
                begin
                    if (bus_wr && adr_i == `ABCD_OFS_INSN)
                        phase_reg <= PH_DECODE;
                end
                PH_DECODE: phase_reg <= PH_READ;
                PH_READ: phase_reg <= PH_PROC;
                PH_PROC: phase_reg <= PH_WRITE;
                PH_WRITE:
                begin
                    // A taken branch spends four more whole cycles doing nothing
                    if (taken_reg && !extra_reg)
                    begin
                        phase_reg <= PH_DECODE;
                        extra_reg <= 1'b1;
                    end
                    else
                    begin
                        phase_reg <= PH_IDLE;
                        extra_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Pipeline latches
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            op_reg <= OP_NONE;
            operand_reg <= `ABCD_RST_BYTE;
            result_reg <= `ABCD_RST_BYTE;
            new_flags_reg <= `ABCD_RST_FLAGS;
            mask_reg <= `ABCD_RST_FLAGS;
            taken_reg <= 1'b0;
        end
        else
        begin
            if (phase_reg == PH_DECODE && !extra_reg)
            begin
                op_reg <= op_next;
                taken_reg <= 1'b0;
            end
            if (phase_reg == PH_READ && !extra_reg)
                operand_reg <= is_file_op ? mem_rd : insn_reg[7:0];
            if (phase_reg == PH_PROC && !extra_reg)
            begin
                result_reg <= alu_result;
                new_flags_reg <= alu_flags;
                mask_reg <= alu_mask;
                taken_reg <= (op_reg == OP_BRANCH) && flags_reg[`ABCD_FLAG_C];
            end
        end
    end

    // ****************************************
    // Architectural registers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            insn_reg <= `ABCD_RST_INSN;
            working_register_reg <= `ABCD_RST_BYTE;
            flags_reg <= `ABCD_RST_FLAGS;
            bank_select_register_reg <= `ABCD_RST_BANK;
            program_counter_reg <= '0;
            maddr_reg <= '0;
        end
        else if (idle)
        begin
            if (bus_wr)
            begin
                unique case (adr_i)
                    `ABCD_OFS_INSN: insn_reg <= wr_word[15:0];
                    `ABCD_OFS_WORK: working_register_reg <= wr_word[7:0];
                    `ABCD_OFS_FLAGS: flags_reg <= wr_word[4:0];
                    `ABCD_OFS_BANK: bank_select_register_reg <= wr_word[3:0];
                    `ABCD_OFS_PC: program_counter_reg <= wr_word[PC_W-1:0];
                    `ABCD_OFS_MADDR: maddr_reg <= wr_word[MEM_AW-1:0];
                    default: maddr_reg <= maddr_reg;
                endcase
            end
        end
        else if (phase_reg == PH_WRITE && !extra_reg)
        begin
            if ((!is_file_op || !insn_reg[`ABCD_BIT_D]) && op_reg != OP_BRANCH
                && op_reg != OP_NONE)
                working_register_reg <= result_reg;
            flags_reg <= (flags_reg & ~mask_reg) | (new_flags_reg & mask_reg);
            program_counter_reg <= program_counter_reg + PC_W'(`ABCD_PC_STEP)
                + (taken_reg ? branch_offset : '0);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    phase_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_DECODE |=> phase_reg == PH_READ ##1 phase_reg == PH_PROC
        ##1 phase_reg == PH_WRITE)
        else $error("phase order broken");
    add_literal_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_PROC && op_reg == OP_ADD_LIT |=> ##1
        working_register_reg == 8'($past(working_register_reg, 2) + $past(operand_reg, 2)))
        else $error("literal add wrong");
    add_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_WRITE && !extra_reg && mask_reg == 5'h1f |=>
        flags_reg[`ABCD_FLAG_Z] == ($past(result_reg) == 8'h00))
        else $error("add zero flag wrong");
    dest_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_WRITE && !extra_reg && is_file_op && !insn_reg[`ABCD_BIT_D]
        |-> !mem_we ##1 working_register_reg == $past(result_reg))
        else $error("destination select wrong");
    bank_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_READ && insn_reg[`ABCD_BIT_A] |->
        mem_addr[MEM_AW-1:8] == bank_select_register_reg)
        else $error("bank select not used");
    add_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_PROC && !extra_reg && op_reg == OP_ADDC_FILE |=>
        result_reg == 8'($past(working_register_reg) + $past(operand_reg)
        + {7'h00, $past(flags_reg[`ABCD_FLAG_C])}))
        else $error("carry add wrong");
    and_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_WRITE && (op_reg == OP_AND_LIT || op_reg == OP_AND_FILE) |=>
        $stable(flags_reg[`ABCD_FLAG_C]) && $stable(flags_reg[`ABCD_FLAG_NIB])
        && $stable(flags_reg[`ABCD_FLAG_SRANGE]))
        else $error("and touched carry flags");
    branch_target_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_WRITE && !extra_reg && taken_reg |=>
        program_counter_reg == $past(program_counter_reg) + PC_W'(`ABCD_PC_STEP)
        + $past(branch_offset) && $stable(flags_reg))
        else $error("branch target wrong");
    branch_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_WRITE && !extra_reg && taken_reg |=> extra_reg
        ##3 phase_reg == PH_WRITE ##1 phase_reg == PH_IDLE)
        else $error("taken branch length wrong");
    single_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_reg == PH_WRITE && !taken_reg |=> phase_reg == PH_IDLE)
        else $error("instruction overran one cycle");

endmodule

// file: abcd_data_mem.sv
// Purpose: Banked file register memory
// Assumes: Single write port, asynchronous read
// Notes: Contents are not reset
`timescale 1ns/10ps

module abcd_data_mem #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] rd_data_o
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[addr_i];

endmodule

// file: abcd_params.svh
// Purpose: Offsets, field positions, opcodes and reset values of the decoder
// Assumes: Included by every file that needs a constant
// Notes: Definitions only
`ifndef ABCD_PARAMS_SVH
`define ABCD_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ABCD_OFS_INSN 8'h00
`define ABCD_OFS_WORK 8'h04
`define ABCD_OFS_FLAGS 8'h08
`define ABCD_OFS_BANK 8'h0c
`define ABCD_OFS_PC 8'h10
`define ABCD_OFS_MADDR 8'h14
`define ABCD_OFS_MDATA 8'h18

// ****************************************
// Flag bit positions in the flags register
// ****************************************
`define ABCD_FLAG_C 0
`define ABCD_FLAG_NIB 1
`define ABCD_FLAG_Z 2
`define ABCD_FLAG_SRANGE 3
`define ABCD_FLAG_N 4
`define ABCD_FLAG_BUSY 8

// ****************************************
// Instruction fields and opcodes
// ****************************************
`define ABCD_OPC_ADD_LIT 8'h0f
`define ABCD_OPC_AND_LIT 8'h0b
`define ABCD_OPC_BRANCH 8'he2
`define ABCD_OPC_ADD_FILE 6'h09
`define ABCD_OPC_ADDC_FILE 6'h08
`define ABCD_OPC_AND_FILE 6'h05
`define ABCD_BIT_D 9
`define ABCD_BIT_A 8
`define ABCD_ACCESS_SPLIT 8'h80
`define ABCD_ACCESS_LOW_BANK 4'h0
`define ABCD_ACCESS_HIGH_BANK 4'hf
`define ABCD_PC_STEP 2

// ****************************************
// Reset values
// ****************************************
`define ABCD_RST_BYTE 8'h00
`define ABCD_RST_INSN 16'h0000
`define ABCD_RST_FLAGS 5'h00
`define ABCD_RST_BANK 4'h0

`endif

// file: abcd_pkg.sv
// Purpose: Types shared by the decoder modules
// Assumes: Nothing
// Notes: Phase and operation codes are one-hot
package abcd_pkg;

    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_DECODE = 5'b00010,
        PH_READ = 5'b00100,
        PH_PROC = 5'b01000,
        PH_WRITE = 5'b10000
    } abcd_phase_type;

    typedef enum logic [6:0] {
        OP_NONE = 7'b0000001,
        OP_ADD_LIT = 7'b0000010,
        OP_AND_LIT = 7'b0000100,
        OP_ADD_FILE = 7'b0001000,
        OP_ADDC_FILE = 7'b0010000,
        OP_AND_FILE = 7'b0100000,
        OP_BRANCH = 7'b1000000
    } abcd_op_type;

endpackage

// file: tb_top.sv
// Purpose: Self-checking bench for the add, AND and branch-on-carry core
// Assumes: Classic Wishbone single cycles; one instruction in flight at a time
// Notes: Each read notes its expected data in a queue; the ack monitor compares
`timescale 1ns/10ps
`include "abcd_params.svh"

module tb_top;
    import abcd_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic busy_o;
    int bad_count = 0;
    int num_checks = 0;
    int cyc_cnt = 0;
    int seed = 85189;
    logic [31:0] exp_q[$];
    logic [20:0] pc_m = 21'h0;
    logic [3:0] sel_m = 4'hf;

    abcd_core DUT (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .busy_o(busy_o)
    );

    always #10 clk_i = ~clk_i;

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Read data is valid only in the ack cycle, so it is taken at that edge
    always @(posedge clk_i)
    begin
        if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0)
        begin
            if (exp_q.size() == 0)
                check(dat_o, 32'hdeadbeef);
            else
                check(dat_o, exp_q.pop_front());
        end
    end

    // Generous ceiling: the whole run needs well under 5000 cycles
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Bus cycles and instruction launch
    // ****************************************
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= adr;
        dat_i <= dat;
        sel_i <= sel_m;
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, adr, 32'h0);
    endtask

    // Counts busy cycles; every executed word advances the counter by one word
    task automatic exec(input logic [15:0] insn, output int len);
        len = 0;
        wr(`ABCD_OFS_INSN, {16'h0, insn});
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clk_i);
            if (busy_o === 1'b1)
                len++;
            else if (len > 0)
                break;
        end
        pc_m = pc_m + 21'd2;
    endtask

    function automatic logic [12:0] add_model(input logic [7:0] a, input logic [7:0] b,
        input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        logic [4:0] f;
        s = {1'b0, a} + {1'b0, b} + {8'h0, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        f = 5'h00;
        f[`ABCD_FLAG_C] = s[8];
        f[`ABCD_FLAG_NIB] = h[4];
        f[`ABCD_FLAG_Z] = (s[7:0] == 8'h00);
        f[`ABCD_FLAG_SRANGE] = (a[7] == b[7]) && (s[7] != a[7]);
        f[`ABCD_FLAG_N] = s[7];
        return {f, s[7:0]};
    endfunction

    // Only sign and zero move; the other flags must survive the AND
    function automatic logic [12:0] and_model(input logic [4:0] old, input logic [7:0] a,
        input logic [7:0] b);
        logic [4:0] f;
        f = old;
        f[`ABCD_FLAG_Z] = ((a & b) == 8'h00);
        f[`ABCD_FLAG_N] = a[7] & b[7];
        return {f, a & b};
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [7:0] w;
        logic [7:0] k;
        logic [7:0] m;
        logic [4:0] fl;
        logic [3:0] bk;
        logic [3:0] bank_e;
        logic [5:0] opc;
        logic [12:0] r;
        logic [20:0] pc_e;
        int len;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`ABCD_OFS_WORK, 32'h0);
        rd(`ABCD_OFS_FLAGS, 32'h0);
        rd(`ABCD_OFS_BANK, 32'h0);
        rd(`ABCD_OFS_PC, 32'h0);
        rd(`ABCD_OFS_INSN, 32'h0);
        wr(8'h1c, 32'hffffffff);
        rd(8'h1c, 32'h0);
        $display("test reset_and_unmapped done");
        for (int i = 0; i < 10; i++)
        begin
            w = 8'($random(seed));
            k = 8'($random(seed));
            fl = 5'($random(seed));
            if (i < 2)
                w = (i == 0) ? 8'h7f : 8'hff;
            if (i < 4)
                k = 8'h01;
            wr(`ABCD_OFS_WORK, {24'h0, w});
            wr(`ABCD_OFS_FLAGS, {27'h0, fl});
            if (i % 2 == 0)
                r = add_model(w, k, 1'b0);
            else
                r = and_model(fl, w, k);
            exec({(i % 2 == 0) ? `ABCD_OPC_ADD_LIT : `ABCD_OPC_AND_LIT, k}, len);
            check(32'(len), 32'd4);
            rd(`ABCD_OFS_WORK, {24'h0, r[7:0]});
            rd(`ABCD_OFS_FLAGS, {27'h0, r[12:8]});
            rd(`ABCD_OFS_PC, {11'h0, pc_m});
        end
        $display("test literal_ops done");
        for (int op = 0; op < 3; op++)
            for (int d = 0; d < 2; d++)
                for (int a = 0; a < 2; a++)
                begin
                    w = 8'($random(seed));
                    m = 8'($random(seed));
                    k = (a == 0) ? ((d == 0) ? 8'h7f : 8'h80) : 8'($random(seed));
                    fl = 5'($random(seed));
                    bk = 4'($random(seed));
                    bank_e = (a == 1) ? bk : (k[7] ? `ABCD_ACCESS_HIGH_BANK
                        : `ABCD_ACCESS_LOW_BANK);
                    wr(`ABCD_OFS_BANK, {28'h0, bk});
                    wr(`ABCD_OFS_WORK, {24'h0, w});
                    wr(`ABCD_OFS_FLAGS, {27'h0, fl});
                    wr(`ABCD_OFS_MADDR, {20'h0, bank_e, k});
                    wr(`ABCD_OFS_MDATA, {24'h0, m});
                    opc = (op == 0) ? `ABCD_OPC_ADD_FILE
                        : ((op == 1) ? `ABCD_OPC_ADDC_FILE : `ABCD_OPC_AND_FILE);
                    if (op == 2)
                        r = and_model(fl, w, m);
                    else
                        r = add_model(w, m, (op == 1) ? fl[`ABCD_FLAG_C] : 1'b0);
                    exec({opc, d[0], a[0], k}, len);
                    check(32'(len), 32'd4);
                    rd(`ABCD_OFS_WORK, {24'h0, (d == 1) ? w : r[7:0]});
                    rd(`ABCD_OFS_FLAGS, {27'h0, r[12:8]});
                    rd(`ABCD_OFS_MDATA, {24'h0, (d == 1) ? r[7:0] : m});
                end
        $display("test file_ops done");
        for (int i = 0; i < 6; i++)
        begin
            k = (i < 2) ? 8'h80 : ((i < 4) ? 8'h7f : 8'($random(seed)));
            fl = 5'($random(seed));
            fl[`ABCD_FLAG_C] = (i % 2 == 1);
            pc_m = 21'h000400;
            wr(`ABCD_OFS_PC, {11'h0, pc_m});
            wr(`ABCD_OFS_FLAGS, {27'h0, fl});
            exec({`ABCD_OPC_BRANCH, k}, len);
            pc_e = pc_m + (fl[`ABCD_FLAG_C] ? {{12{k[7]}}, k, 1'b0} : 21'h0);
            check(32'(len), fl[`ABCD_FLAG_C] ? 32'd8 : 32'd4);
            rd(`ABCD_OFS_PC, {11'h0, pc_e});
            rd(`ABCD_OFS_FLAGS, {27'h0, fl});
        end
        $display("test branch_on_carry done");
        pc_m = 21'h000100;
        w = 8'($random(seed));
        k = 8'($random(seed));
        fl = 5'($random(seed));
        bk = 4'($random(seed));
        wr(`ABCD_OFS_PC, {11'h0, pc_m});
        wr(`ABCD_OFS_WORK, {24'h0, w});
        wr(`ABCD_OFS_FLAGS, {27'h0, fl});
        wr(`ABCD_OFS_BANK, {28'h0, bk});
        // Unknown word: only the counter may move
        exec({8'hff, k}, len);
        check(32'(len), 32'd4);
        rd(`ABCD_OFS_PC, {11'h0, pc_m});
        rd(`ABCD_OFS_WORK, {24'h0, w});
        rd(`ABCD_OFS_FLAGS, {27'h0, fl});
        // The flag read and the bank write are answered while a word still runs
        r = add_model(w, k, 1'b0);
        wr(`ABCD_OFS_INSN, {16'h0, `ABCD_OPC_ADD_LIT, k});
        rd(`ABCD_OFS_FLAGS, (32'h1 << `ABCD_FLAG_BUSY) | {27'h0, fl});
        while (busy_o === 1'b1)
            @(posedge clk_i);
        wr(`ABCD_OFS_INSN, {16'h0, `ABCD_OPC_AND_LIT, 8'hff});
        wr(`ABCD_OFS_BANK, {28'h0, ~bk});
        while (busy_o === 1'b1)
            @(posedge clk_i);
        rd(`ABCD_OFS_BANK, {28'h0, bk});
        rd(`ABCD_OFS_WORK, {24'h0, r[7:0]});
        sel_m = 4'he;
        wr(`ABCD_OFS_WORK, {24'hffffff, ~r[7:0]});
        rd(`ABCD_OFS_WORK, {24'h0, r[7:0]});
        sel_m = 4'h1;
        wr(`ABCD_OFS_WORK, {24'hffffff, k});
        sel_m = 4'hf;
        rd(`ABCD_OFS_WORK, {24'h0, k});
        $display("test nop_busy_lanes done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`ABCD_OFS_PC, 32'h0);
        rd(`ABCD_OFS_WORK, 32'h0);
        rd(`ABCD_OFS_FLAGS, 32'h0);
        $display("test mid_run_reset done");
        repeat (3) @(posedge clk_i);
        check(32'(exp_q.size()), 32'd0);
        tally_and_finish();
    end
endmodule
